// ===== acrc_defines.svh
// constants for the calibration sequencer and rate selection
// Function
// RULE_01: internal full-scale above gain one takes four cycles chopped, two unchopped.
// RULE_02: ready indication goes high at calibration start, low when it finishes.
// RULE_03: a finished calibration puts the mode to idle by itself.
// RULE_04: full-scale calibrations write gain coefficient to the selected channel's register.
// RULE_05: internal full-scale is refused at gain 128; host uses system full-scale.
// RULE_06: mode 110 is system zero-scale, two cycles chopped, one unchopped.
// RULE_07: system zero-scale writes offset coefficient to the selected channel's register.
// RULE_08: host applies the system zero or full-scale input before asking.
// RULE_09: mode 111 is system full-scale, two cycles chopped, one unchopped.
// RULE_10: host should recalibrate full-scale whenever it changes a channel gain.
// RULE_11: rate codes 1 to 15 select 470 down to 4.17 Hz; code 0 none.
// RULE_12: settling 4 to 480 ms chopped; unchopped halves settling, same rate.
// RULE_13: internal full-scale at gain one takes two cycles chopped, one unchopped.
// RULE_14: idle holds filter and modulator in reset, modulator clocks keep running.
// RULE_15: internal zero-scale shorts the channel and stores its offset coefficient.
`ifndef ACRC_DEFINES_SVH
`define ACRC_DEFINES_SVH

`define ACRC_MODE_CONT 3'h0
`define ACRC_MODE_SINGLE 3'h1
`define ACRC_MODE_IDLE 3'h2
`define ACRC_MODE_PDOWN 3'h3
`define ACRC_MODE_INT_ZS 3'h4
`define ACRC_MODE_INT_FS 3'h5
`define ACRC_MODE_SYS_ZS 3'h6
`define ACRC_MODE_SYS_FS 3'h7
`define ACRC_MODE_RESET 3'h0

`define ACRC_GAIN_1 3'h0
`define ACRC_GAIN_128 3'h7

`define ACRC_CYC_BASE_CHOP 3'h2
`define ACRC_CYC_BASE_NOCHOP 3'h1
`define ACRC_CYC_HIGH_CHOP 3'h4
`define ACRC_CYC_HIGH_NOCHOP 3'h2

`define ACRC_CLK_HZ 64'h0000_0000_0ee6_b280
`define ACRC_CHZ_PER_HZ 64'h0000_0000_0000_0064

`define ACRC_RATE_NONE 4'h0
`define ACRC_COEF_W 24

`endif

// ===== acrc_pkg.sv
// types shared by the calibration sequencer
`default_nettype none
package acrc_pkg;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_CAL = 2'b10
  } acrc_state_t;
  typedef logic [2:0] acrc_mode_t;
  typedef logic [2:0] acrc_cyc_t;
endpackage
`default_nettype wire

// ===== acrc_rate_timer.sv
// rate lookup and conversion-cycle tick divider
`include "acrc_defines.svh"
`default_nettype none
module acrc_rate_timer #(
  parameter longint CLK_HZ = `ACRC_CLK_HZ
) (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic restart_in,
  input wire logic chop_en_in,
  input wire logic [3:0] rate_code_in,
  output logic tick_out,
  output logic rate_valid_out,
  output logic [15:0] rate_chz_out,
  output logic [9:0] settle_half_ms_out
);
  // ----------------------------------------
  // rate table, output rate in 0.01 Hz
  // ----------------------------------------
  function automatic logic [15:0] rate_chz(input logic [3:0] code);
    logic [15:0] r;
    r = 16'h0000;
    unique case (code)
      4'h1: r = 16'hB798;
      4'h2: r = 16'h5E88;
      4'h3: r = 16'h300C;
      4'h4: r = 16'h1838;
      4'h5: r = 16'h1388;
      4'h6: r = 16'h0F3C;
      4'h7: r = 16'h0CF8;
      4'h8: r = 16'h07A8;
      4'h9: r = 16'h0686;
      4'hA: r = 16'h0686;
      4'hB: r = 16'h04E2;
      4'hC: r = 16'h03E8;
      4'hD: r = 16'h0341;
      4'hE: r = 16'h0271;
      4'hF: r = 16'h01A1;
      default: r = 16'h0000;
    endcase
    return r;
  endfunction

  function automatic logic [8:0] settle_ms(input logic [3:0] code);
    logic [8:0] s;
    s = 9'h000;
    unique case (code)
      4'h1: s = 9'h004;
      4'h2: s = 9'h008;
      4'h3: s = 9'h010;
      4'h4: s = 9'h020;
      4'h5: s = 9'h028;
      4'h6: s = 9'h030;
      4'h7: s = 9'h03C;
      4'h8: s = 9'h065;
      4'h9: s = 9'h078;
      4'hA: s = 9'h078;
      4'hB: s = 9'h0A0;
      4'hC: s = 9'h0C8;
      4'hD: s = 9'h0F0;
      4'hE: s = 9'h140;
      4'hF: s = 9'h1E0;
      default: s = 9'h000;
    endcase
    return s;
  endfunction

  // ----------------------------------------
  // clock cycles per conversion, per code
  // ----------------------------------------
  logic [31:0] period_tab [16];
  genvar i;
  generate
    for (i = 0; i < 16; i++) begin : g_period
      localparam longint CHZ = longint'(rate_chz(4'(i)));
      localparam longint P = (CHZ == 0) ? 64'h0000_0000_0000_0001
                                        : (CLK_HZ * `ACRC_CHZ_PER_HZ) / CHZ;
      assign period_tab[i] = 32'(P);
    end
  endgenerate

  logic [31:0] cnt_q;
  logic valid;
  assign valid = (rate_code_in != `ACRC_RATE_NONE);

  // restart aligns the first tick one full conversion after a calibration start
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      cnt_q <= 32'h0000_0000;
      tick_out <= 1'b0;
    end else if (restart_in || !valid) begin
      cnt_q <= 32'h0000_0000;
      tick_out <= 1'b0;
    end else if (cnt_q >= period_tab[rate_code_in] - 32'h0000_0001) begin
      cnt_q <= 32'h0000_0000;
      tick_out <= 1'b1;
    end else begin
      cnt_q <= cnt_q + 32'h0000_0001;
      tick_out <= 1'b0;
    end
  end

  // unchopped settling is half, so report in half milliseconds to stay exact
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      rate_valid_out <= 1'b0;
      rate_chz_out <= 16'h0000;
      settle_half_ms_out <= 10'h000;
    end else begin
      rate_valid_out <= valid;                                 // see RULE_11
      rate_chz_out <= rate_chz(rate_code_in);                  // see RULE_11
      settle_half_ms_out <= chop_en_in ? {settle_ms(rate_code_in), 1'b0}
                                       : {1'b0, settle_ms(rate_code_in)}; // see RULE_12
    end
  end
endmodule
`default_nettype wire

// ===== acrc_cal_ctrl.sv
// calibration sequencer and mode holder for the converter core
`include "acrc_defines.svh"
`default_nettype none
module acrc_cal_ctrl #(
  parameter longint CLK_HZ = `ACRC_CLK_HZ
) (
  input wire logic CLK_IN,
  input wire logic RST_IN,
  input wire logic MODE_WR_IN,
  input wire logic [2:0] MODE_IN,
  input wire logic [2:0] GAIN_IN,
  input wire logic CHOP_EN_IN,
  input wire logic CHANNEL_SELECT_BIT2_IN,
  input wire logic CHANNEL_SELECT_BIT1_IN,
  input wire logic CHANNEL_SELECT_BIT0_IN,
  input wire logic RATE_CODE_BIT3_IN,
  input wire logic RATE_CODE_BIT2_IN,
  input wire logic RATE_CODE_BIT1_IN,
  input wire logic RATE_CODE_BIT0_IN,
  input wire logic [23:0] MEAS_COEF_IN,
  output logic [2:0] MODE_OUT,
  output logic RDY_N_OUT,
  output logic CAL_BUSY_OUT,
  output logic CAL_REFUSED_OUT,
  output logic FILTER_RESET_OUT,
  output logic MOD_CLK_EN_OUT,
  output logic INT_SHORT_OUT,
  output logic INT_FS_REF_OUT,
  output logic CONV_TICK_OUT,
  output logic OFFSET_WE_OUT,
  output logic FULLSCALE_WE_OUT,
  output logic [2:0] COEF_CH_OUT,
  output logic [23:0] COEF_OUT,
  output logic RATE_VALID_OUT,
  output logic [15:0] RATE_CHZ_OUT,
  output logic [9:0] SETTLE_HALF_MS_OUT
);
  // ----------------------------------------
  // request decode
  // ----------------------------------------
  acrc_pkg::acrc_state_t state_q;
  acrc_pkg::acrc_mode_t mode_q;
  acrc_pkg::acrc_mode_t cal_mode_q;
  acrc_pkg::acrc_cyc_t need_q;
  acrc_pkg::acrc_cyc_t need_d;
  acrc_pkg::acrc_cyc_t done_q;
  logic [2:0] chan_sel;
  logic [3:0] rate_code;
  logic is_cal_req;
  logic refuse;
  logic start;
  logic tick;
  logic finish;

  assign chan_sel = {CHANNEL_SELECT_BIT2_IN, CHANNEL_SELECT_BIT1_IN, CHANNEL_SELECT_BIT0_IN};
  assign rate_code = {RATE_CODE_BIT3_IN, RATE_CODE_BIT2_IN, RATE_CODE_BIT1_IN,
                      RATE_CODE_BIT0_IN};
  assign is_cal_req = MODE_IN[2];
  // internal full-scale cannot run at the top gain; mode stays as it was
  assign refuse = MODE_WR_IN && (MODE_IN == `ACRC_MODE_INT_FS)
                  && (GAIN_IN == `ACRC_GAIN_128);                    // see RULE_05
  // writes during a calibration are ignored so a coefficient is never half-measured
  assign start = MODE_WR_IN && is_cal_req && !refuse && (state_q == acrc_pkg::ST_IDLE);
  assign finish = (state_q == acrc_pkg::ST_CAL) && tick && (done_q == need_q - 3'h1);

  // ----------------------------------------
  // conversion cycles per calibration
  // ----------------------------------------
  always_comb begin
    need_d = CHOP_EN_IN ? `ACRC_CYC_BASE_CHOP : `ACRC_CYC_BASE_NOCHOP; // see RULE_06 RULE_09
    if (MODE_IN == `ACRC_MODE_INT_FS && GAIN_IN != `ACRC_GAIN_1) begin
      need_d = CHOP_EN_IN ? `ACRC_CYC_HIGH_CHOP : `ACRC_CYC_HIGH_NOCHOP; // see RULE_01
    end
    // gain one and zero-scale kinds keep the base count, see RULE_13 RULE_15
  end

  // ----------------------------------------
  // sequencer
  // ----------------------------------------
  always_ff @(posedge CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      state_q <= acrc_pkg::ST_IDLE;
      cal_mode_q <= `ACRC_MODE_IDLE;
      need_q <= 3'h1;
      done_q <= 3'h0;
      COEF_CH_OUT <= 3'h0;
    end else begin
      unique case (state_q)
        acrc_pkg::ST_IDLE: begin
          if (start) begin
            state_q <= acrc_pkg::ST_CAL;
            cal_mode_q <= MODE_IN;
            need_q <= need_d;
            done_q <= 3'h0;
            COEF_CH_OUT <= chan_sel;   // channel fixed for the whole calibration
          end
        end
        acrc_pkg::ST_CAL: begin
          if (finish) begin
            state_q <= acrc_pkg::ST_IDLE;
          end else if (tick) begin
            done_q <= done_q + 3'h1;
          end
        end
        default: begin
          state_q <= acrc_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------
  // operating mode
  // ----------------------------------------
  always_ff @(posedge CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      mode_q <= `ACRC_MODE_RESET;
    end else if (finish) begin
      mode_q <= `ACRC_MODE_IDLE;                                    // see RULE_03
    end else if (MODE_WR_IN && !refuse && state_q == acrc_pkg::ST_IDLE) begin
      mode_q <= MODE_IN;
    end
  end

  // ready indication, high means no result pending
  always_ff @(posedge CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      RDY_N_OUT <= 1'b1;
    end else if (start) begin
      RDY_N_OUT <= 1'b1;                                            // see RULE_02
    end else if (finish) begin
      RDY_N_OUT <= 1'b0;                                            // see RULE_02
    end
  end

  // ----------------------------------------
  // coefficient write-back
  // ----------------------------------------
  always_ff @(posedge CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      OFFSET_WE_OUT <= 1'b0;
      FULLSCALE_WE_OUT <= 1'b0;
      COEF_OUT <= 24'h00_0000;
      CAL_REFUSED_OUT <= 1'b0;
    end else begin
      OFFSET_WE_OUT <= finish && !cal_mode_q[0];                   // see RULE_07 RULE_15
      FULLSCALE_WE_OUT <= finish && cal_mode_q[0];                 // see RULE_04
      CAL_REFUSED_OUT <= refuse;                                   // see RULE_05
      if (finish) begin
        COEF_OUT <= MEAS_COEF_IN;
      end
    end
  end

  // ----------------------------------------
  // analog front controls
  // ----------------------------------------
  assign MODE_OUT = mode_q;
  assign CAL_BUSY_OUT = (state_q == acrc_pkg::ST_CAL);
  // power-down also stops clocks; idle keeps them, see RULE_14
  assign FILTER_RESET_OUT = (mode_q == `ACRC_MODE_IDLE) || (mode_q == `ACRC_MODE_PDOWN);
  assign MOD_CLK_EN_OUT = (mode_q != `ACRC_MODE_PDOWN);
  assign INT_SHORT_OUT = CAL_BUSY_OUT && (cal_mode_q == `ACRC_MODE_INT_ZS); // see RULE_15
  assign INT_FS_REF_OUT = CAL_BUSY_OUT && (cal_mode_q == `ACRC_MODE_INT_FS);
  assign CONV_TICK_OUT = tick;

  acrc_rate_timer #(
    .CLK_HZ(CLK_HZ)
  ) u_timer (
    .clk_in(CLK_IN),
    .rst_in(RST_IN),
    .restart_in(start),
    .chop_en_in(CHOP_EN_IN),
    .rate_code_in(rate_code),
    .tick_out(tick),
    .rate_valid_out(RATE_VALID_OUT),
    .rate_chz_out(RATE_CHZ_OUT),
    .settle_half_ms_out(SETTLE_HALF_MS_OUT)
  );
endmodule
`default_nettype wire

// ===== acrc_core_model.sv
// converter core stand-in that supplies the measured coefficient
`default_nettype none
module acrc_core_model (
  input wire logic clk_in,
  input wire logic rst_in,
  output var logic [23:0] coef_out
);
  timeunit 1ns;
  timeprecision 1ps;
  // value moves every cycle, so a late or early capture shows up
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) coef_out <= 24'h13_5791;
    else coef_out <= coef_out + 24'h0a_3c5f;
  end
endmodule
`default_nettype wire

// ===== acrc_cal_props.sv
// assertion checker for the calibration sequencer
`default_nettype none
module acrc_cal_props (
  input wire logic CLK_IN,
  input wire logic RST_IN,
  input wire logic MODE_WR_IN,
  input wire logic [2:0] MODE_IN,
  input wire logic [2:0] GAIN_IN,
  input wire logic CHOP_EN_IN,
  input wire logic CHANNEL_SELECT_BIT2_IN,
  input wire logic CHANNEL_SELECT_BIT1_IN,
  input wire logic CHANNEL_SELECT_BIT0_IN,
  input wire logic [23:0] MEAS_COEF_IN,
  input wire logic [2:0] MODE_OUT,
  input wire logic RDY_N_OUT,
  input wire logic CAL_BUSY_OUT,
  input wire logic CAL_REFUSED_OUT,
  input wire logic CONV_TICK_OUT,
  input wire logic OFFSET_WE_OUT,
  input wire logic FULLSCALE_WE_OUT,
  input wire logic [2:0] COEF_CH_OUT,
  input wire logic [23:0] COEF_OUT
);
  default clocking cb @(posedge CLK_IN); endclocking
  default disable iff (RST_IN);
  logic acc, bad;
  logic [2:0] n_q, cnt_q, ch_sel;
  assign acc = MODE_WR_IN && !CAL_BUSY_OUT;
  assign ch_sel = {CHANNEL_SELECT_BIT2_IN, CHANNEL_SELECT_BIT1_IN, CHANNEL_SELECT_BIT0_IN};
  assign bad = MODE_IN == 3'h5 && GAIN_IN == 3'h7;
  // expected conversion cycles, latched at the accepted write
  always_ff @(posedge CLK_IN or posedge RST_IN) begin
    if (RST_IN) n_q <= 3'h0;
    else if (acc && MODE_IN[2] && !bad)
      n_q <= (MODE_IN == 3'h5 && GAIN_IN != 3'h0) ? (CHOP_EN_IN ? 3'h4 : 3'h2)
        : (CHOP_EN_IN ? 3'h2 : 3'h1);
  end
  always_ff @(posedge CLK_IN or posedge RST_IN) begin
    if (RST_IN) cnt_q <= 3'h0;
    else if (!CAL_BUSY_OUT) cnt_q <= 3'h0;
    else if (CONV_TICK_OUT) cnt_q <= cnt_q + 3'h1;
  end
  a_cal_start: assert property (acc && MODE_IN[2] && !bad |=> RDY_N_OUT && CAL_BUSY_OUT
    && MODE_OUT == $past(MODE_IN)) else $error("calibration start wrong");
  a_refuse_pulse: assert property (acc && bad |=> CAL_REFUSED_OUT && !CAL_BUSY_OUT
    && $stable(MODE_OUT)) else $error("gain 128 request not refused");
  a_end_idle: assert property ($fell(CAL_BUSY_OUT) |-> MODE_OUT == 3'h2 && !RDY_N_OUT)
    else $error("no idle or ready at end");
  a_cycle_count: assert property ($fell(CAL_BUSY_OUT) |-> $past(CONV_TICK_OUT)
    && cnt_q == n_q) else $error("calibration length wrong");
  a_we_kind: assert property ($fell(CAL_BUSY_OUT) |-> FULLSCALE_WE_OUT == $past(MODE_OUT[0])
    && OFFSET_WE_OUT == !$past(MODE_OUT[0])) else $error("wrong coefficient write");
  a_we_only_end: assert property (OFFSET_WE_OUT || FULLSCALE_WE_OUT |-> $fell(CAL_BUSY_OUT))
    else $error("coefficient write outside end");
  a_coef_value: assert property ($fell(CAL_BUSY_OUT) |-> COEF_OUT == $past(MEAS_COEF_IN))
    else $error("coefficient value wrong");
  a_coef_chan: assert property ($rose(CAL_BUSY_OUT) |-> COEF_CH_OUT == $past(ch_sel))
    else $error("coefficient channel wrong");
  a_busy_ready: assert property (CAL_BUSY_OUT |-> RDY_N_OUT)
    else $error("ready low while calibrating");
endmodule
bind acrc_cal_ctrl acrc_cal_props i_props (.*);
`default_nettype wire

// ===== acrc_cal_ctrl_tb.sv
// self-checking bench for the calibration sequencer
`default_nettype none
module acrc_cal_ctrl_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int PER = 212; // code 1 tick period at the shortened clock
  logic clk, rst = 1, wr = 0, chop = 0, rdy_n, busy, refused, filt_rst, tick, owe, fwe, rvalid;
  logic [2:0] mode = 0, gain = 0, ch = 0, mode_o, coef_ch;
  logic int_short, int_fs, mclk;
  logic [3:0] rate = 4'h1;
  logic [23:0] coef, coef_o;
  logic [15:0] rchz;
  logic [9:0] settle;
  int fails = 0, comparisons = 0;
  int chz[16] = '{0, 47000, 24200, 12300, 6200, 5000, 3900, 3320, 1960, 1670, 1670, 1250, 1000,
    833, 625, 417};
  int ms[16] = '{0, 4, 8, 16, 32, 40, 48, 60, 101, 120, 120, 160, 200, 240, 320, 480};
  acrc_cal_ctrl #(.CLK_HZ(100000)) i_dut (.CLK_IN(clk), .RST_IN(rst), .MODE_WR_IN(wr),
    .MODE_IN(mode), .GAIN_IN(gain), .CHOP_EN_IN(chop), .CHANNEL_SELECT_BIT2_IN(ch[2]),
    .CHANNEL_SELECT_BIT1_IN(ch[1]), .CHANNEL_SELECT_BIT0_IN(ch[0]), .RATE_CODE_BIT3_IN(rate[3]),
    .RATE_CODE_BIT2_IN(rate[2]), .RATE_CODE_BIT1_IN(rate[1]), .RATE_CODE_BIT0_IN(rate[0]),
    .MEAS_COEF_IN(coef), .MODE_OUT(mode_o), .RDY_N_OUT(rdy_n), .CAL_BUSY_OUT(busy),
    .CAL_REFUSED_OUT(refused), .FILTER_RESET_OUT(filt_rst), .MOD_CLK_EN_OUT(mclk),
    .INT_SHORT_OUT(int_short), .INT_FS_REF_OUT(int_fs), .CONV_TICK_OUT(tick), .OFFSET_WE_OUT(owe),
    .FULLSCALE_WE_OUT(fwe), .COEF_CH_OUT(coef_ch), .COEF_OUT(coef_o), .RATE_VALID_OUT(rvalid),
    .RATE_CHZ_OUT(rchz), .SETTLE_HALF_MS_OUT(settle));
  acrc_core_model i_core (.clk_in(clk), .rst_in(rst), .coef_out(coef));
  initial begin
    clk = 0;
    forever #2 clk = ~clk;
  end
  task automatic chk(input string what, input logic [23:0] exp, input logic [23:0] got);
    comparisons++;
    if (got !== exp) begin
      fails++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic put(input logic [2:0] m, g, input logic c, input logic [2:0] k);
    mode = m; gain = g; chop = c; ch = k; wr = 1;
    @(negedge clk);
    wr = 0;
  endtask
  task automatic run_cal(input logic [2:0] m, g, input logic c, input logic [2:0] k, input int n);
    int t;
    logic [23:0] mv;
    t = 0;
    put(m, g, c, k);
    chk("ready at start", {1'b1, m}, {rdy_n, mode_o});
    chk("front switch", {m == 3'h4, m == 3'h5}, {int_short, int_fs});
    while (rdy_n !== 1'b0 && t < 2000) begin
      mv = coef;
      @(negedge clk);
      t++;
    end
    chk("cycles", n * PER + 1, t);
    chk("idle mode", {3'h2, 4'b1100}, {mode_o, filt_rst, mclk, int_short, int_fs});
    chk("write kind", {!m[0], m[0], k}, {owe, fwe, coef_ch});
    chk("coefficient", mv, coef_o);
    @(negedge clk);
    chk("write pulse", 0, owe | fwe);
  endtask
  task automatic t_sys_cal;
    run_cal(3'h6, 3'h3, 1, 3'h5, 2);
    run_cal(3'h6, 3'h3, 0, 3'h2, 1);
    run_cal(3'h7, 3'h7, 1, 3'h1, 2);
    run_cal(3'h7, 3'h0, 0, 3'h6, 1);
    $display("system calibration test done");
  endtask
  task automatic t_int_cal;
    run_cal(3'h5, 3'h3, 1, 3'h4, 4);
    run_cal(3'h5, 3'h6, 0, 3'h3, 2);
    run_cal(3'h5, 3'h0, 1, 3'h7, 2);
    run_cal(3'h5, 3'h0, 0, 3'h0, 1);
    run_cal(3'h4, 3'h7, 1, 3'h2, 2);
    run_cal(3'h4, 3'h0, 0, 3'h5, 1);
    $display("internal calibration test done");
  endtask
  task automatic t_refuse;
    put(3'h5, 3'h7, 1, 3'h1);
    chk("refused", {1'b1, 1'b0, 3'h2}, {refused, busy, mode_o});
    @(negedge clk);
    chk("refused pulse", 0, refused);
    $display("refusal test done");
  endtask
  task automatic t_modes;
    for (int i = 0; i < 4; i++) begin
      put(i[2:0], 3'h0, 1'b1, 3'h0);
      chk("plain mode", {i[2:0], i == 2 || i == 3, i != 3}, {mode_o, filt_rst, mclk});
      @(negedge clk);
    end
    $display("plain mode test done");
  endtask
  task automatic t_rates;
    for (int i = 0; i < 32; i++) begin
      rate = i[3:0];
      chop = i[4];
      repeat (2) @(negedge clk);
      chk("rate", {i % 16 != 0, 16'(chz[i % 16])}, {rvalid, rchz});
      chk("settling", ms[i % 16] * (chop ? 2 : 1), settle);
    end
    $display("rate table test done");
  endtask
  task automatic print_verdict;
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial begin
    repeat (20) @(negedge clk);
    chk("reset ready", {1'b1, 3'h0}, {rdy_n, mode_o});
    rst = 0;
    @(negedge clk);
    t_sys_cal;
    t_int_cal;
    t_refuse;
    t_modes;
    t_rates;
    print_verdict;
  end
  // about four thousand cycles expected; generous margin
  initial begin
    repeat (20000) @(posedge clk);
    fails++;
    print_verdict;
  end
endmodule
`default_nettype wire
